// ### hw/dlc_hbin.sv
// Horizontal pair binning stage of the pixel combiner
`timescale 1ns/10ps
`include "dlc_params.svh"
module dlc_hbin
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Control
    input wire logic bin_en_in,
    // Combined pixel stream in
    input wire logic in_valid_in,
    input wire dlc_sum_t in_pix_in,
    input wire logic in_last_in,
    // Binned pixel stream out
    output logic out_valid_out,
    output dlc_bin_t out_pix_out,
    output logic out_last_out
);

    logic odd_phase;
    dlc_sum_t held;

    // Pair phase and first pixel of a pair
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            odd_phase <= 1'b0;
            held <= '0;
        end else if (in_valid_in && bin_en_in) begin
            held <= in_pix_in;
            odd_phase <= !odd_phase && !in_last_in; // Line end restarts pairing
        end
    end

    // Output: pass through, or one sum per pair
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_valid_out <= 1'b0;
            out_pix_out <= '0;
            out_last_out <= 1'b0;
        end else begin
            out_valid_out <= 1'b0;
            out_last_out <= 1'b0;
            if (in_valid_in && !bin_en_in) begin
                out_valid_out <= 1'b1;
                out_pix_out <= {1'b0, in_pix_in};
                out_last_out <= in_last_in;
            end else if (in_valid_in && odd_phase) begin
                out_valid_out <= 1'b1;
                out_pix_out <= {1'b0, held} + {1'b0, in_pix_in};
                out_last_out <= in_last_in;
            end else if (in_valid_in && in_last_in) begin
                // Odd pixel at line end leaves alone
                out_valid_out <= 1'b1;
                out_pix_out <= {1'b0, in_pix_in};
                out_last_out <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_pair_sum;
        in_valid_in && bin_en_in && odd_phase |=>
            out_valid_out && out_pix_out == $past(held) + $past(in_pix_in);
    endproperty
    a_pair_sum: assert property (p_pair_sum) else $error("pair sum wrong");

    property p_first_held;
        in_valid_in && bin_en_in && !odd_phase && !in_last_in |=> !out_valid_out;
    endproperty
    a_first_held: assert property (p_first_held) else $error("unpaired pixel sent");

    property p_pass;
        in_valid_in && !bin_en_in |=> out_valid_out && out_pix_out == {1'b0, $past(in_pix_in)};
    endproperty
    a_pass: assert property (p_pass) else $error("unbinned pass wrong");

endmodule

// ### hw/dlc_pixel_combiner.sv
// Dual line pixel combiner: exposure sequencing, line buffer, combining, ROI, registers
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`include "dlc_params.svh"
module dlc_pixel_combiner
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Acquisition trigger pin
    input wire logic trigger_in,
    // Sensor control, both lines together
    output logic expose_out,
    output logic readout_req_out,
    // Sensor readout, both lines side by side
    input wire logic pix_valid_in,
    input wire dlc_pix_t pix_a_in,
    input wire dlc_pix_t pix_b_in,
    input wire logic pix_last_in,
    // Combined output line
    output logic out_valid_out,
    output dlc_bin_t out_pix_out,
    output logic out_last_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] acq_mode;
    logic [1:0] delay_sel;
    logic hbin_en;
    logic [15:0] expose_cycles;
    dlc_idx_t roi_start;
    logic [`DLC_IDX_W:0] roi_len;
    logic [15:0] lines_out;
    logic buf_valid;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_edge;
    dlc_state_e state;
    logic [15:0] expose_cnt;
    logic accept;
    dlc_idx_t pix_idx;
    dlc_pix_t line_buf [0:`DLC_LINE_MAX-1];
    dlc_pix_t prev_val;
    dlc_pix_t delayed_val;
    dlc_pix_t live_val;
    logic delayed_mode;
    dlc_sum_t next_comb;
    logic next_emit;
    logic comb_valid;
    dlc_sum_t comb_pix;
    logic comb_last;
    logic bin_valid;
    dlc_bin_t bin_pix;
    logic bin_last;
    dlc_idx_t roi_idx;
    logic [`DLC_IDX_W:0] roi_end;
    logic in_roi;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------

    // Mode, binning, exposure and ROI settings
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acq_mode <= `DLC_RST_ACQ;
            delay_sel <= `DLC_RST_DLY;
            hbin_en <= `DLC_RST_HBIN;
            expose_cycles <= `DLC_RST_EXPOSE;
            roi_start <= `DLC_RST_ROI_START;
            roi_len <= `DLC_RST_ROI_LEN;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `DLC_ADDR_MODE: begin
                    acq_mode <= reg_wdata_in[`DLC_ACQ_LSB +: 2];
                    delay_sel <= reg_wdata_in[`DLC_DLY_LSB +: 2];
                end
                `DLC_ADDR_HBIN: hbin_en <= reg_wdata_in[`DLC_HBIN_BIT];
                `DLC_ADDR_EXPOSE: expose_cycles <= reg_wdata_in[15:0];
                `DLC_ADDR_ROI_START: roi_start <= reg_wdata_in[`DLC_IDX_W-1:0];
                `DLC_ADDR_ROI_LEN: roi_len <= reg_wdata_in[`DLC_IDX_W:0];
                default: ;
            endcase
        end
    end

    // Read data, valid only the cycle after the strobe
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h00000000;
        end else begin
            reg_rdata_out <= 32'h00000000;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    `DLC_ADDR_MODE: begin
                        reg_rdata_out[`DLC_ACQ_LSB +: 2] <= acq_mode;
                        reg_rdata_out[`DLC_DLY_LSB +: 2] <= delay_sel;
                    end
                    `DLC_ADDR_HBIN: reg_rdata_out[`DLC_HBIN_BIT] <= hbin_en;
                    `DLC_ADDR_EXPOSE: reg_rdata_out[15:0] <= expose_cycles;
                    `DLC_ADDR_ROI_START: reg_rdata_out[`DLC_IDX_W-1:0] <= roi_start;
                    `DLC_ADDR_ROI_LEN: reg_rdata_out[`DLC_IDX_W:0] <= roi_len;
                    `DLC_ADDR_STATUS: begin
                        reg_rdata_out[2:0] <= state;
                        reg_rdata_out[`DLC_STAT_BUF_BIT] <= buf_valid;
                        reg_rdata_out[`DLC_STAT_LINES_LSB +: 16] <= lines_out;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger and exposure sequencing
    // ------------------------------------------------------------

    // Two-stage synchroniser plus edge history
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= trigger_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    assign trig_edge = trig_s2 && !trig_s3;

    // Expose both lines, then request readout of both
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_IDLE;
            expose_cnt <= 16'h0000;
            expose_out <= 1'b0;
            readout_req_out <= 1'b0;
        end else begin
            readout_req_out <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (trig_edge) begin
                        state <= ST_EXPOSE;
                        expose_cnt <= expose_cycles;
                        expose_out <= 1'b1;
                    end
                end
                ST_EXPOSE: begin
                    if (expose_cnt == 16'h0000) begin
                        state <= ST_READ;
                        expose_out <= 1'b0;
                        readout_req_out <= 1'b1;
                    end else begin
                        expose_cnt <= expose_cnt - 16'h0001;
                    end
                end
                ST_READ: begin
                    if (accept && pix_last_in) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Line buffer and combining
    // ------------------------------------------------------------

    assign accept = pix_valid_in && (state == ST_READ);
    assign delayed_mode = dlc_is_delayed(acq_mode, delay_sel);

    // Pixel index along the line
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pix_idx <= '0;
        end else if (accept) begin
            pix_idx <= pix_last_in ? '0 : pix_idx + 13'h0001;
        end
    end

    // Buffer holds the delayed line for the next acquisition
    always_ff @(posedge ref_clk_in) begin
        if (accept && delayed_mode) begin
            line_buf[pix_idx] <= delayed_val;
        end
    end

    // Buffer content valid after one full delayed line
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            buf_valid <= 1'b0;
        end else if (accept && pix_last_in && delayed_mode) begin
            buf_valid <= 1'b1; // Completed line wins over a mode write
        end else if (reg_wr_in && reg_addr_in == `DLC_ADDR_MODE) begin
            buf_valid <= 1'b0;
        end
    end

    // Pick delayed and live lines, then sum or average
    always_comb begin
        prev_val = line_buf[pix_idx];
        delayed_val = (delay_sel == `DLC_DLY_B) ? pix_b_in : pix_a_in;
        live_val = (delay_sel == `DLC_DLY_B) ? pix_a_in : pix_b_in;
        next_comb = {1'b0, pix_a_in};
        if (acq_mode == `DLC_ACQ_SUM) begin
            next_comb = delayed_mode ? dlc_add(prev_val, live_val)
                                     : dlc_add(pix_a_in, pix_b_in);
        end else if (acq_mode == `DLC_ACQ_AVG) begin
            next_comb = delayed_mode ? dlc_half_up(dlc_add(prev_val, live_val))
                                     : dlc_half_up(dlc_add(pix_a_in, pix_b_in));
        end
        next_emit = accept && (!delayed_mode || buf_valid);
    end

    // Combined pixel stage, one ordinary line out
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            comb_valid <= 1'b0;
            comb_pix <= '0;
            comb_last <= 1'b0;
        end else begin
            comb_valid <= next_emit;
            comb_pix <= next_comb;
            comb_last <= pix_last_in;
        end
    end

    // Optional pair binning
    dlc_hbin u_hbin (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .bin_en_in(hbin_en),
        .in_valid_in(comb_valid),
        .in_pix_in(comb_pix),
        .in_last_in(comb_last),
        .out_valid_out(bin_valid),
        .out_pix_out(bin_pix),
        .out_last_out(bin_last)
    );

    // ------------------------------------------------------------
    // Region of interest on the output line
    // ------------------------------------------------------------

    assign roi_end = {1'b0, roi_start} + roi_len;
    assign in_roi = ({1'b0, roi_idx} >= {1'b0, roi_start}) && ({1'b0, roi_idx} < roi_end);

    // Output index counts binned pixels
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            roi_idx <= '0;
        end else if (bin_valid) begin
            roi_idx <= bin_last ? '0 : roi_idx + 13'h0001;
        end
    end

    // Output register and line counter
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_valid_out <= 1'b0;
            out_pix_out <= '0;
            out_last_out <= 1'b0;
            lines_out <= 16'h0000;
        end else begin
            out_valid_out <= bin_valid && in_roi;
            out_pix_out <= bin_pix;
            out_last_out <= bin_valid && in_roi
                && (bin_last || {1'b0, roi_idx} == roi_end - 14'h0001);
            if (bin_valid && bin_last) begin
                lines_out <= lines_out + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_trig_idle;
        state == ST_IDLE && trig_edge;
    endsequence

    sequence s_expose_run;
        expose_out && state == ST_EXPOSE;
    endsequence

    property p_expose_start;
        s_trig_idle |=> s_expose_run;
    endproperty
    a_expose_start: assert property (p_expose_start) else $error("exposure did not start");

    property p_readout_after;
        (s_expose_run and expose_cnt == 16'h0000) |=>
            readout_req_out && !expose_out ##1 !readout_req_out && state == ST_READ;
    endproperty
    a_readout_after: assert property (p_readout_after) else $error("readout not requested");

    property p_buf_write;
        accept && delayed_mode |=> line_buf[$past(pix_idx)] == $past(delayed_val);
    endproperty
    a_buf_write: assert property (p_buf_write) else $error("delayed line not buffered");

    property p_swap;
        accept && delayed_mode && delay_sel == `DLC_DLY_B |=>
            line_buf[$past(pix_idx)] == $past(pix_b_in);
    endproperty
    a_swap: assert property (p_swap) else $error("line B not buffered");

    property p_td_sum;
        accept && buf_valid && delayed_mode && acq_mode == `DLC_ACQ_SUM |=>
            comb_valid && comb_pix == {1'b0, $past(prev_val)} + {1'b0, $past(live_val)};
    endproperty
    a_td_sum: assert property (p_td_sum) else $error("delayed sum wrong");

    property p_avg;
        accept && !delayed_mode && acq_mode == `DLC_ACQ_AVG |=>
            comb_valid && comb_pix ==
            13'(({2'b00, $past(pix_a_in)} + {2'b00, $past(pix_b_in)} + 14'h0001) >> 1);
    endproperty
    a_avg: assert property (p_avg) else $error("average wrong");

    property p_td_avg;
        accept && buf_valid && delayed_mode && acq_mode == `DLC_ACQ_AVG |=>
            comb_valid && comb_pix ==
            13'(({2'b00, $past(prev_val)} + {2'b00, $past(live_val)} + 14'h0001) >> 1);
    endproperty
    a_td_avg: assert property (p_td_avg) else $error("delayed average wrong");

    property p_first_dropped;
        accept && delayed_mode && !buf_valid |=> !comb_valid;
    endproperty
    a_first_dropped: assert property (p_first_dropped) else $error("stale line sent");

    property p_single_a;
        accept && acq_mode == `DLC_ACQ_SINGLE |=> comb_valid && comb_pix == {1'b0, $past(pix_a_in)};
    endproperty
    a_single_a: assert property (p_single_a) else $error("single line not A");

    property p_roi_gate;
        bin_valid && !in_roi |=> !out_valid_out;
    endproperty
    a_roi_gate: assert property (p_roi_gate) else $error("pixel outside ROI sent");

endmodule

// ### inc/dlc_params.svh
// Constants of the dual line pixel combiner: offsets, fields, codes, resets
// Summary of operation
// - Summing trigger exposes both lines, then reads out
// - Delayed line pixels go into line buffer
// - Live pixel adds buffered pixel of same index
// - Sums leave as one ordinary output line
// - Either line may be the delayed one
// - Averaging: pair sum halved, rounded up
// - Averages leave as one ordinary output line
// - Delayed averaging: delayed sum halved, rounded up
// - Binning is an enable for every mode
// - Binning adds adjacent pixel pairs of line
// - Second line binned the same way when used
// - Single line binning uses first line only
// - Binned output line is half sensor length, rounded up for an odd line
// - Region of interest counts binned pixels
`ifndef DLC_PARAMS_SVH
`define DLC_PARAMS_SVH

// ------------------------------------------------------------
// Geometry and widths
// ------------------------------------------------------------
`define DLC_PIX_W 12
`define DLC_LINE_MAX 8192
`define DLC_IDX_W 13

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define DLC_ADDR_MODE 8'h00
`define DLC_ADDR_HBIN 8'h04
`define DLC_ADDR_EXPOSE 8'h08
`define DLC_ADDR_ROI_START 8'h0C
`define DLC_ADDR_ROI_LEN 8'h10
`define DLC_ADDR_STATUS 8'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DLC_ACQ_LSB 0
`define DLC_DLY_LSB 2
`define DLC_HBIN_BIT 0
`define DLC_STAT_BUF_BIT 4
`define DLC_STAT_LINES_LSB 16

// ------------------------------------------------------------
// Mode and delay codes
// ------------------------------------------------------------
`define DLC_ACQ_SINGLE 2'h0
`define DLC_ACQ_SUM 2'h1
`define DLC_ACQ_AVG 2'h2
`define DLC_DLY_NONE 2'h0
`define DLC_DLY_A 2'h1
`define DLC_DLY_B 2'h2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DLC_RST_ACQ 2'h0
`define DLC_RST_DLY 2'h0
`define DLC_RST_HBIN 1'h0
`define DLC_RST_EXPOSE 16'h0064
`define DLC_RST_ROI_START 13'h0000
`define DLC_RST_ROI_LEN 14'h2000

`endif

// ### inc/dlc_pkg.sv
// Types and shared helpers of the dual line pixel combiner
`include "dlc_params.svh"
package dlc_pkg;

    typedef logic [`DLC_PIX_W-1:0] dlc_pix_t;
    typedef logic [`DLC_PIX_W:0] dlc_sum_t;
    typedef logic [`DLC_PIX_W+1:0] dlc_bin_t;
    typedef logic [`DLC_IDX_W-1:0] dlc_idx_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXPOSE = 3'b010,
        ST_READ = 3'b100
    } dlc_state_e;

    // True when one line is held back a whole acquisition
    function automatic logic dlc_is_delayed(input logic [1:0] acq, input logic [1:0] dly);
        return (acq != `DLC_ACQ_SINGLE) && (dly != `DLC_DLY_NONE);
    endfunction

    // Widened sum of two pixels
    function automatic dlc_sum_t dlc_add(input dlc_pix_t a, input dlc_pix_t b);
        return {1'b0, a} + {1'b0, b};
    endfunction

    // Halve a sum, rounding up
    function automatic dlc_sum_t dlc_half_up(input dlc_sum_t s);
        logic [`DLC_PIX_W+1:0] t;
        t = {1'b0, s} + 14'h0001;
        return t[`DLC_PIX_W+1:1];
    endfunction

endpackage

// ### tb/dlc_sensor_model.sv
// Sensor readout model: answers a readout request with one line of paired pixels
`timescale 1ns/10ps
module dlc_sensor_model
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Request and pattern control
    input wire logic readout_req_in,
    input wire logic slow_in,
    input wire logic [3:0] len_in,
    input wire dlc_pix_t seed_a_in,
    input wire dlc_pix_t seed_b_in,
    // Readout stream
    output logic pix_valid_out,
    output dlc_pix_t pix_a_out,
    output dlc_pix_t pix_b_out,
    output logic pix_last_out,
    output logic busy_out
);
    logic [3:0] idx;
    logic gap;

    // ------------------------------------------------------------
    // Readout sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_out <= 1'b0;
            idx <= 4'h0;
            gap <= 1'b0;
            pix_valid_out <= 1'b0;
            pix_last_out <= 1'b0;
            pix_a_out <= 12'h000;
            pix_b_out <= 12'h000;
        end else begin
            gap <= slow_in && !gap;
            pix_valid_out <= 1'b0;
            pix_last_out <= 1'b0;
            pix_a_out <= ~pix_a_out; // Idle lines carry no stale value
            pix_b_out <= ~pix_b_out;
            if (readout_req_in) begin
                busy_out <= 1'b1; // Both lines read together
                idx <= 4'h0;
            end else if (busy_out && !gap) begin
                pix_valid_out <= 1'b1;
                pix_a_out <= seed_a_in + 12'(idx); // Same index on both lines
                pix_b_out <= seed_b_in + 12'({idx, 1'b0});
                pix_last_out <= (idx == len_in - 4'h1);
                busy_out <= (idx != len_in - 4'h1);
                idx <= idx + 4'h1;
            end
        end
    end
endmodule

// ### tb/dual_line_pixel_combiner_tb.sv
// Self-checking bench of the dual line pixel combiner
`timescale 1ns/10ps
`include "dlc_params.svh"
module dual_line_pixel_combiner_tb;
    import dlc_pkg::*;
    typedef struct packed {logic [1:0] acq; logic [1:0] dly; logic hb; logic [3:0] n;} dlc_row_s;
    localparam dlc_pix_t A1 = 12'hFF0, B1 = 12'hF01, A2 = 12'h123, B2 = 12'hFE5;
    logic ref_clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic trigger_in = 1'b0, expose_out, readout_req_out, pix_valid_in, pix_last_in, busy;
    dlc_pix_t pix_a_in, pix_b_in, seed_a = 12'h000, seed_b = 12'h000;
    logic out_valid_out, out_last_out, slow = 1'b0;
    dlc_bin_t out_pix_out;
    logic [3:0] len = 4'h6;
    int fail_count = 0, total_checks = 0, cyc = 0, expo = 101, n;
    dlc_bin_t got_pix[$];
    logic got_last[$];
    dlc_row_s rows [10] = '{'{2'h0, 2'h0, 1'b0, 4'h6}, '{2'h1, 2'h0, 1'b0, 4'h6},
        '{2'h2, 2'h0, 1'b0, 4'h6}, '{2'h1, 2'h1, 1'b0, 4'h6}, '{2'h1, 2'h2, 1'b0, 4'h6},
        '{2'h2, 2'h1, 1'b0, 4'h6}, '{2'h2, 2'h2, 1'b0, 4'h6}, '{2'h0, 2'h0, 1'b1, 4'h3},
        '{2'h1, 2'h1, 1'b1, 4'h3}, '{2'h2, 2'h0, 1'b1, 4'h3}};

    dlc_pixel_combiner dut (.ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .trigger_in, .expose_out, .readout_req_out, .pix_valid_in,
        .pix_a_in, .pix_b_in, .pix_last_in, .out_valid_out, .out_pix_out, .out_last_out);
    dlc_sensor_model sensor (.ref_clk_in, .rst_b_in, .readout_req_in(readout_req_out),
        .slow_in(slow), .len_in(len), .seed_a_in(seed_a), .seed_b_in(seed_b),
        .pix_valid_out(pix_valid_in), .pix_a_out(pix_a_in), .pix_b_out(pix_b_in),
        .pix_last_out(pix_last_in), .busy_out(busy));

    // ------------------------------------------------------------
    // Clock, output capture and hang limit
    // ------------------------------------------------------------
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (out_valid_out === 1'b1) begin
            got_pix.push_back(out_pix_out);
            got_last.push_back(out_last_out);
        end
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk("rdata", reg_rdata_out, exp);
        @(posedge ref_clk_in);
        #1 chk("rdata_idle", reg_rdata_out, 32'h0);
    endtask
    // One triggered acquisition, exposure length checked
    task automatic acq_line(input dlc_pix_t sa, input dlc_pix_t sb);
        int k;
        n = 0;
        seed_a <= sa;
        seed_b <= sb;
        trigger_in <= 1'b1;
        for (k = 0; k < 400; k++) begin
            @(posedge ref_clk_in);
            if (k == 3) trigger_in <= 1'b0;
            if (readout_req_out === 1'b1) break;
            n += int'(expose_out === 1'b1);
        end
        @(posedge ref_clk_in); // Sensor raises busy at the break edge, seen only from this edge
        chk("expose_len", n, expo);
        for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge ref_clk_in);
        repeat (6) @(posedge ref_clk_in);
    endtask
    // Expected combined pixel from the mode rules
    function automatic dlc_bin_t comb(input logic [1:0] acq, input logic [1:0] dly, input int i);
        dlc_bin_t x, y, s;
        x = 14'(12'(A2 + i[11:0]));
        y = (acq == `DLC_ACQ_SINGLE) ? 14'h0000 : 14'(12'(B2 + {i[10:0], 1'b0}));
        if (acq != `DLC_ACQ_SINGLE && dly == `DLC_DLY_A) x = 14'(12'(A1 + i[11:0]));
        if (acq != `DLC_ACQ_SINGLE && dly == `DLC_DLY_B) begin
            x = 14'(12'(B1 + {i[10:0], 1'b0}));
            y = 14'(12'(A2 + i[11:0]));
        end
        s = x + y;
        return (acq == `DLC_ACQ_AVG) ? ((s + 14'h0001) >> 1) : s;
    endfunction
    function automatic dlc_bin_t exp_out(input logic [1:0] acq, input logic [1:0] dly,
                                         input logic hb, input int j);
        if (!hb) return comb(acq, dly, j);
        if (2 * j + 1 >= int'(len)) return comb(acq, dly, 2 * j);
        return comb(acq, dly, 2 * j) + comb(acq, dly, 2 * j + 1);
    endfunction
    task automatic chk_line(input logic [1:0] acq, input logic [1:0] dly, input logic hb,
                            input int st, input int cnt);
        int k;
        chk("out_count", got_pix.size(), cnt);
        for (k = 0; k < cnt && k < got_pix.size(); k++) begin
            chk("out_pix", 32'(got_pix[k]), 32'(exp_out(acq, dly, hb, st + k)));
            chk("out_last", 32'(got_last[k]), 32'(k == cnt - 1));
        end
        got_pix.delete();
        got_last.delete();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd(`DLC_ADDR_MODE, 32'h0);
        rd(`DLC_ADDR_HBIN, 32'h0);
        rd(`DLC_ADDR_EXPOSE, 32'h64);
        rd(`DLC_ADDR_ROI_LEN, 32'h2000);
        rd(8'h20, 32'h0);
        rd(`DLC_ADDR_STATUS, 32'h1);
        $display("register reset test done");
        wr(`DLC_ADDR_EXPOSE, 32'h3);
        expo = 4;
        foreach (rows[r]) begin
            wr(`DLC_ADDR_MODE, {28'h0, rows[r].dly, rows[r].acq});
            wr(`DLC_ADDR_HBIN, {31'h0, rows[r].hb});
            if (rows[r].dly != `DLC_DLY_NONE) begin
                acq_line(A1, B1);
                chk_line(rows[r].acq, rows[r].dly, rows[r].hb, 0, 0);
            end
            acq_line(A2, B2);
            chk_line(rows[r].acq, rows[r].dly, rows[r].hb, 0, int'(rows[r].n));
            $display("mode row %0d done", r);
        end
        // Odd line with a slow sensor, then a region of interest in binned units
        wr(`DLC_ADDR_MODE, 32'h1);
        slow <= 1'b1;
        len <= 4'h5;
        acq_line(A2, B2);
        chk_line(2'h1, 2'h0, 1'b1, 0, 3);
        slow <= 1'b0;
        len <= 4'h8;
        wr(`DLC_ADDR_ROI_START, 32'h1);
        wr(`DLC_ADDR_ROI_LEN, 32'h2);
        acq_line(A2, B2);
        chk_line(2'h1, 2'h0, 1'b1, 1, 2);
        $display("odd line and region test done");
        // Second trigger during exposure is ignored
        wr(`DLC_ADDR_EXPOSE, 32'h14);
        trigger_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        trigger_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        trigger_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        trigger_in <= 1'b0;
        n = 0;
        repeat (80) begin
            @(posedge ref_clk_in);
            n += int'(readout_req_out === 1'b1);
        end
        chk("readout_count", n, 1);
        $display("trigger refusal test done");
        final_report();
    end
endmodule
